// *** fhf_cfg.svh ***
`ifndef FHF_CFG_SVH
`define FHF_CFG_SVH
`define FHF_OFF_CTRL    8'h00
`define FHF_OFF_AUXLEN  8'h04
`define FHF_OFF_DATA    8'h08
`define FHF_OFF_LEN0    8'h0C
`define FHF_OFF_LEN1    8'h10
`define FHF_OFF_SKIP    8'h14
`define FHF_CTRL_HDR    0
`define FHF_CTRL_TIME   1
`define FHF_CTRL_TAG1   2
`define FHF_CTRL_TAG2   3
`define FHF_CTRL_RST    4'h3
`define FHF_AUXLEN_RST  4'h8
`define FHF_AUX_MAX     4'h8
`define FHF_DEPTH       12'h800
`define FHF_FRAME_MAX   21
`define FHF_KIND_REG    2'h2
`define FHF_KIND_CTL    2'h1
`define FHF_OP_SKIP     4'h0
`define FHF_OP_TIME     4'h1
`define FHF_OP_CFG      4'h2
`define FHF_HDR_OVER    8'h80
`define FHF_PAY_OVER    8'h00
`define FHF_SKIP_MAX    8'hFF
`define FHF_LEN_CFG     5'h05
`define FHF_AXIS_BYTES  6
`define FHF_TIME_LAST   2'h3
`endif

// *** fhf_pkg.sv ***
`default_nettype none
package fhf_pkg;
    typedef struct packed {
        logic        aux_en;
        logic        gyr_en;
        logic        acc_en;
        logic [63:0] aux;
        logic [47:0] gyr;
        logic [47:0] acc;
    } fhf_sample_t;
    typedef struct packed {
        logic aux_interface_changed;
        logic aux_config_changed;
        logic gyro_range_changed;
        logic gyro_config_changed;
        logic accel_range_changed;
        logic accel_config_changed;
    } fhf_chg_flags_t;
    typedef struct packed {
        logic           valid;
        logic           sensor_enabled;
        fhf_chg_flags_t flags;
    } fhf_cfgchg_t;
    typedef enum logic [1:0] {RD_MEM, RD_SKIP, RD_TIME, RD_OVER} fhf_rd_state_t;
    typedef enum logic {WR_IDLE, WR_BYTE} fhf_wr_state_t;
endpackage
`default_nettype wire

// *** fhf_framer.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "fhf_cfg.svh"
// Notes on behaviour
// (R1) Header byte: kind in 7:6, parameter in 5:2, tag in 1:0.
// (R2) Kind 10 is a sensor frame, 01 a control frame, others reserved.
// (R3) Reading past stored data returns header 0x80 then payload 0x00.
// (R4) Parameter bit0 accel, bit1 gyro, bit2 aux present; bit3 reserved zero.
// (R5) Tag bits carry only the two event pin levels.
// (R6) Payload order aux, gyro XYZ, accel XYZ, low byte first.
// (R7) A sensor frame is stored only if it holds at least one sensor.
// (R8) Aux block up to 8 bytes, shortened to configured burst length.
// (R9) Control frames only appear while header mode is on.
// (R10) Opcodes: 0 skip one byte, 1 time three bytes, 2 config four bytes.
// (R11) Fill count in two registers, counting bytes of stored frames, not time frames.
// (R12) After drops a skip frame reports the count, saturating at 0xFF.
// (R13) Skip frame leads a read burst and uses no storage.
// (R14) Emptying burst appends time frame captured at last frame byte.
// (R15) Time frames only while the time enable bit is set.
// (R16) Config change frame is stored before the next sensor frame.
// (R17) Config payload byte 0 holds six change flags, bits 7:6 zero.
// (R18) Config payload bytes 1..3 carry sensortime, low byte first.
// (R19) Each flag is set when its configuration write becomes active.
// (R20) Buffer or sensor enable produces a config frame with zero flags.
// (R21) A fully read frame is removed; a partial one is replayed whole.
// (R22) Each data register read of a stored byte moves the read position one byte.
module fhf_framer
    import fhf_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        sample_valid,
    input  wire fhf_sample_t sample,
    output logic             sample_ready,
    input  wire fhf_cfgchg_t cfg_chg,
    input  wire logic [23:0] sensortime,
    input  wire logic        event_pin_one,
    input  wire logic        event_pin_two
);
    // ----------------------------------------
    // Storage and state
    // ----------------------------------------
    logic [7:0]    mem [0:2047];
    logic          mark [0:2047];
    logic [7:0]    frame_r [0:`FHF_FRAME_MAX-1];
    logic [7:0]    nb [0:`FHF_FRAME_MAX-1];
    logic [3:0]    ctrl_r;
    logic [3:0]    auxlen_r;
    logic [11:0]   fill_r;
    logic [11:0]   rd_cnt_r;
    logic [10:0]   rd_ptr_r;
    logic [10:0]   frm_start_r;
    logic [10:0]   wr_ptr_r;
    logic [7:0]    skip_r;
    logic [7:0]    skip_hold_r;
    logic [1:0]    tidx_r;
    logic [23:0]   time_cap_r;
    logic          burst_r;
    fhf_rd_state_t rd_state_r;
    fhf_rd_state_t rd_state_nxt;
    fhf_wr_state_t wr_state_r;
    logic [4:0]    wlen_r;
    logic [4:0]    widx_r;
    logic          chg_pend_r;
    logic [5:0]    chg_flags_r;
    logic [1:0]    pin_s1_r;
    logic [1:0]    pin_s2_r;
    logic          ready_r;
    logic [31:0]   prdata_r;
    logic          pslverr_r;
    logic          hdr;
    logic          acc;
    logic          is_data_rd;
    logic          other_acc;
    logic [7:0]    rd_byte;
    logic          rd_adv;
    logic          rd_commit;
    logic          skip_take;
    logic          time_go;
    logic [4:0]    nlen;
    logic [3:0]    aux_n;
    logic [1:0]    tag_w;
    logic          cfg_take;
    logic          cfg_drop;
    logic          reg_ok;
    logic          start;
    logic          fit;
    logic          drop;
    logic          wr_done;
    assign hdr        = ctrl_r[`FHF_CTRL_HDR];
    assign acc        = psel & penable & ~ready_r;
    assign is_data_rd = acc & ~pwrite & (paddr == `FHF_OFF_DATA);
    assign other_acc  = acc & ~is_data_rd;
    assign pready     = ready_r;
    assign prdata     = prdata_r;
    assign pslverr    = pslverr_r;

    // ----------------------------------------
    // Event pin synchronisers
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_s1_r <= 2'h0;
            pin_s2_r <= 2'h0;
        end else begin
            pin_s1_r <= {event_pin_two, event_pin_one};
            pin_s2_r <= pin_s1_r;
        end
    end
    assign tag_w = pin_s2_r & {ctrl_r[`FHF_CTRL_TAG2], ctrl_r[`FHF_CTRL_TAG1]}; // R5

    // ----------------------------------------
    // APB slave
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ready_r   <= 1'b0;
            prdata_r  <= 32'h0000_0000;
            pslverr_r <= 1'b0;
            ctrl_r    <= `FHF_CTRL_RST;
            auxlen_r  <= `FHF_AUXLEN_RST;
        end else begin
            ready_r   <= acc;
            if (acc) begin
                pslverr_r <= 1'b0;
                prdata_r  <= 32'h0000_0000;
                if (paddr == `FHF_OFF_CTRL) begin
                    prdata_r <= {28'h000_0000, ctrl_r};
                    if (pwrite) ctrl_r <= pwdata[3:0];
                end else if (paddr == `FHF_OFF_AUXLEN) begin
                    prdata_r <= {28'h000_0000, auxlen_r};
                    if (pwrite) auxlen_r <= pwdata[3:0];
                end else if (paddr == `FHF_OFF_DATA) begin
                    if (!pwrite) prdata_r <= {24'h00_0000, rd_byte}; // R22
                end else if (paddr == `FHF_OFF_LEN0) begin
                    prdata_r <= {24'h00_0000, fill_r[7:0]}; // R11
                end else if (paddr == `FHF_OFF_LEN1) begin
                    prdata_r <= {28'h000_0000, fill_r[11:8]}; // R11
                end else if (paddr == `FHF_OFF_SKIP) begin
                    prdata_r <= {24'h00_0000, skip_r};
                end else begin
                    pslverr_r <= 1'b1;
                end
            end
        end
    end

    // ----------------------------------------
    // Readout byte selection
    // ----------------------------------------
    always_comb begin
        rd_byte      = mem[rd_ptr_r];
        rd_state_nxt = rd_state_r;
        rd_adv       = 1'b0;
        rd_commit    = 1'b0;
        skip_take    = 1'b0;
        time_go      = 1'b0;
        case (rd_state_r)
            RD_SKIP: begin
                rd_byte      = skip_hold_r; // R12
                rd_state_nxt = RD_MEM;
            end
            RD_TIME: begin
                if (tidx_r == 2'h0) rd_byte = {`FHF_KIND_CTL, `FHF_OP_TIME, 2'h0}; // R10
                else if (tidx_r == 2'h1) rd_byte = time_cap_r[7:0];
                else if (tidx_r == 2'h2) rd_byte = time_cap_r[15:8];
                else rd_byte = time_cap_r[23:16];
                if (tidx_r == `FHF_TIME_LAST) rd_state_nxt = RD_MEM;
            end
            RD_OVER: begin
                rd_byte      = `FHF_PAY_OVER; // R3
                rd_state_nxt = RD_MEM;
            end
            default: begin
                if (!burst_r && hdr && skip_r != 8'h00) begin
                    rd_byte      = {`FHF_KIND_CTL, `FHF_OP_SKIP, 2'h0}; // R13
                    skip_take    = 1'b1;
                    rd_state_nxt = RD_SKIP;
                end else if (rd_cnt_r < fill_r) begin
                    rd_adv    = 1'b1; // R22
                    rd_commit = mark[rd_ptr_r];
                    if (rd_commit && (rd_cnt_r + 12'h001 == fill_r) && hdr && ctrl_r[`FHF_CTRL_TIME]) begin
                        time_go      = 1'b1; // R14 R15
                        rd_state_nxt = RD_TIME;
                    end
                end else begin
                    rd_byte      = `FHF_HDR_OVER; // R3
                    rd_state_nxt = RD_OVER;
                end
            end
        endcase
    end

    // ----------------------------------------
    // Read position and burst tracking
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_state_r  <= RD_MEM;
            rd_ptr_r    <= 11'h000;
            rd_cnt_r    <= 12'h000;
            frm_start_r <= 11'h000;
            burst_r     <= 1'b0;
            tidx_r      <= 2'h0;
        end else if (other_acc) begin
            rd_ptr_r   <= frm_start_r; // R21
            rd_cnt_r   <= 12'h000;
            rd_state_r <= RD_MEM;
            burst_r    <= 1'b0;
            tidx_r     <= 2'h0;
        end else if (is_data_rd) begin
            burst_r    <= 1'b1;
            rd_state_r <= rd_state_nxt;
            tidx_r     <= (rd_state_r == RD_TIME) ? tidx_r + 2'h1 : 2'h0;
            if (rd_adv) begin
                rd_ptr_r <= rd_ptr_r + 11'h001;
                rd_cnt_r <= rd_commit ? 12'h000 : rd_cnt_r + 12'h001;
                if (rd_commit) frm_start_r <= rd_ptr_r + 11'h001; // R21
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) time_cap_r <= 24'h00_0000;
        else if (is_data_rd && time_go) time_cap_r <= sensortime; // R14
    end

    // ----------------------------------------
    // Fill count
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) fill_r <= 12'h000;
        else fill_r <= fill_r + (wr_done ? {7'h00, wlen_r} : 12'h000)
                       - ((is_data_rd && rd_commit) ? rd_cnt_r + 12'h001 : 12'h000); // R11
    end

    // ----------------------------------------
    // Skip counter
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            skip_r      <= 8'h00;
            skip_hold_r <= 8'h00;
        end else begin
            if (is_data_rd && skip_take) skip_hold_r <= skip_r;
            if (drop && is_data_rd && skip_take) skip_r <= 8'h01; // R12
            else if (drop) skip_r <= (skip_r == `FHF_SKIP_MAX) ? `FHF_SKIP_MAX : skip_r + 8'h01; // R12
            else if (is_data_rd && skip_take) skip_r <= 8'h00;
        end
    end

    // ----------------------------------------
    // Configuration change tracking
    // ----------------------------------------
    assign cfg_take = (wr_state_r == WR_IDLE) && chg_pend_r && hdr; // R16
    assign cfg_drop = chg_pend_r && !hdr; // R9
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chg_pend_r  <= 1'b0;
            chg_flags_r <= 6'h00;
        end else begin
            chg_pend_r  <= (chg_pend_r && !(cfg_take || cfg_drop)) || cfg_chg.valid; // R20
            chg_flags_r <= ((cfg_take || cfg_drop) ? 6'h00 : chg_flags_r)
                           | ((cfg_chg.valid && !cfg_chg.sensor_enabled) ? cfg_chg.flags : 6'h00); // R19 R20
        end
    end

    // ----------------------------------------
    // Frame builder
    // ----------------------------------------
    always_comb begin
        for (int i = 0; i < `FHF_FRAME_MAX; i++) nb[i] = 8'h00;
        nlen  = 5'h00;
        aux_n = (auxlen_r > `FHF_AUX_MAX) ? `FHF_AUX_MAX : auxlen_r; // R8
        if (cfg_take) begin
            nb[0] = {`FHF_KIND_CTL, `FHF_OP_CFG, 2'h0}; // R10
            nb[1] = {2'h0, chg_flags_r}; // R17
            nb[2] = sensortime[7:0]; // R18
            nb[3] = sensortime[15:8];
            nb[4] = sensortime[23:16];
            nlen  = `FHF_LEN_CFG;
        end else begin
            if (hdr) begin
                nb[0] = {`FHF_KIND_REG, 1'b0, sample.aux_en, sample.gyr_en, sample.acc_en, tag_w}; // R1 R2 R4
                nlen  = 5'h01;
            end
            if (sample.aux_en) begin
                for (int i = 0; i < 8; i++) begin
                    if (i < int'(aux_n)) begin
                        nb[nlen] = sample.aux[8*i +: 8]; // R6 R8
                        nlen     = nlen + 5'h01;
                    end
                end
            end
            if (sample.gyr_en) begin
                for (int i = 0; i < `FHF_AXIS_BYTES; i++) begin
                    nb[nlen] = sample.gyr[8*i +: 8]; // R6
                    nlen     = nlen + 5'h01;
                end
            end
            if (sample.acc_en) begin
                for (int i = 0; i < `FHF_AXIS_BYTES; i++) begin
                    nb[nlen] = sample.acc[8*i +: 8]; // R6
                    nlen     = nlen + 5'h01;
                end
            end
        end
    end

    assign sample_ready = (wr_state_r == WR_IDLE) && !(chg_pend_r && hdr);
    assign reg_ok  = sample_valid && sample_ready && (sample.aux_en || sample.gyr_en || sample.acc_en); // R7
    assign start   = cfg_take || (reg_ok && (nlen > {4'h0, hdr})); // R7
    assign fit     = {7'h00, nlen} <= (`FHF_DEPTH - fill_r);
    assign drop    = start && !fit;
    assign wr_done = (wr_state_r == WR_BYTE) && (widx_r == wlen_r - 5'h01);

    // ----------------------------------------
    // Frame staging
    // ----------------------------------------
    for (genvar g = 0; g < `FHF_FRAME_MAX; g++) begin : g_stage
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) frame_r[g] <= 8'h00;
            else if (start && fit) frame_r[g] <= nb[g];
        end
    end

    // ----------------------------------------
    // Frame writer
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_state_r <= WR_IDLE;
            wr_ptr_r   <= 11'h000;
            wlen_r     <= 5'h00;
            widx_r     <= 5'h00;
        end else begin
            case (wr_state_r)
                WR_IDLE: begin
                    if (start && fit) begin
                        wr_state_r <= WR_BYTE;
                        wlen_r     <= nlen;
                        widx_r     <= 5'h00;
                    end
                end
                default: begin
                    wr_ptr_r <= wr_ptr_r + 11'h001;
                    widx_r   <= widx_r + 5'h01;
                    if (wr_done) wr_state_r <= WR_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge pclk) begin
        if (wr_state_r == WR_BYTE) begin
            mem[wr_ptr_r]  <= frame_r[widx_r];
            mark[wr_ptr_r] <= wr_done;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    a_hdr_fields: assert property (@(posedge pclk) disable iff (!presetn) // R1 R2 R4
        (start && fit && hdr && !cfg_take) |=> (frame_r[0][7:6] == 2'h2) && !frame_r[0][5]
        && (frame_r[0][4:2] == {$past(sample.aux_en), $past(sample.gyr_en), $past(sample.acc_en)}))
        else $error("sensor header fields wrong");
    a_cfg_frame: assert property (@(posedge pclk) disable iff (!presetn) // R10 R18
        (cfg_take && fit) |=> (frame_r[0] == 8'h48) && (wlen_r == 5'h05)
        && (frame_r[2] == $past(sensortime[7:0])))
        else $error("config frame layout wrong");
    a_over_pair: assert property (@(posedge pclk) disable iff (!presetn) // R3
        (is_data_rd && rd_state_r == RD_MEM && burst_r && rd_cnt_r >= fill_r)
        |=> (prdata_r[7:0] == 8'h80) && (rd_state_r == RD_OVER))
        else $error("overread header wrong");
    a_valid_only: assert property (@(posedge pclk) disable iff (!presetn) // R7
        (wr_state_r == WR_IDLE && start && fit && !cfg_take) |-> (nlen > 5'h01 || !hdr))
        else $error("empty sensor frame stored");
    a_ctrl_hdr: assert property (@(posedge pclk) disable iff (!presetn) // R9
        (chg_pend_r && !hdr && !cfg_chg.valid) |=> !chg_pend_r)
        else $error("control frame without header mode");
    a_skip_first: assert property (@(posedge pclk) disable iff (!presetn) // R13
        (is_data_rd && skip_take) |-> !burst_r ##1 (rd_state_r == RD_SKIP) && (prdata_r[7:0] == 8'h40))
        else $error("skip frame not first");
    a_skip_sat: assert property (@(posedge pclk) disable iff (!presetn) // R12
        (drop && skip_r == 8'hFF && !(is_data_rd && skip_take)) |=> (skip_r == 8'hFF))
        else $error("skip count wrapped");
    a_time_gate: assert property (@(posedge pclk) disable iff (!presetn) // R15
        $rose(rd_state_r == RD_TIME) |-> $past(ctrl_r[1]))
        else $error("time frame while disabled");
    a_rd_step: assert property (@(posedge pclk) disable iff (!presetn) // R22
        (is_data_rd && rd_adv) |=> (rd_ptr_r == $past(rd_ptr_r) + 11'h001))
        else $error("read position did not advance");
    a_rewind: assert property (@(posedge pclk) disable iff (!presetn) // R21
        other_acc |=> (rd_ptr_r == $past(frm_start_r)) && (rd_cnt_r == 12'h000))
        else $error("partial frame not replayed");
endmodule // fhf_framer
`default_nettype wire

// *** fhf_host.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Host side: APB master reading frames
// ----------------------------------------
module fhf_host (
    input  wire logic        pclk,
    output var  logic        psel,
    output var  logic        penable,
    output var  logic        pwrite,
    output var  logic [7:0]  paddr,
    output var  logic [31:0] pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h00000000;
    end

    // One transfer, request held until pready is sampled high
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule // fhf_host
`default_nettype wire

// *** test_motion_fifo_header_framer.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "fhf_cfg.svh"
module test_motion_fifo_header_framer
    import fhf_pkg::*;
;
    typedef struct packed {logic [7:0] a; logic [31:0] d; logic e;} fhf_row_t;
    typedef logic [7:0] fhf_bq_t[$];
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, sv, srdy, pin1, pin2;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, r;
    logic [23:0] st;
    fhf_sample_t smp, s;
    fhf_cfgchg_t cc;
    fhf_row_t    rows [8];
    logic        e;
    int          n_errors, n_tests, cyc;

    fhf_framer u_fhf_framer (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sample_valid(sv), .sample(smp), .sample_ready(srdy), .cfg_chg(cc),
        .sensortime(st), .event_pin_one(pin1), .event_pin_two(pin2));
    fhf_host u_fhf_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    // ----------------------------------------
    // Clock, timeout, verdict
    // ----------------------------------------
    always #10 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 60000) begin
            n_errors++;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        if (n_errors == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rdreg(input logic [7:0] a, input logic [31:0] exp);
        u_fhf_host.xfer(1'b0, a, 32'h00000000, r, e);
        chk(r, exp);
    endtask
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        u_fhf_host.xfer(1'b1, a, d, r, e);
    endtask
    task automatic rdq(input fhf_bq_t q);
        foreach (q[i]) begin
            u_fhf_host.xfer(1'b0, `FHF_OFF_DATA, 32'h00000000, r, e);
            chk({24'h000000, r[7:0]}, {24'h000000, q[i]});
        end
    endtask
    task automatic push(input fhf_sample_t x);
        @(posedge pclk);
        sv  <= 1'b1;
        smp <= x;
        do @(negedge pclk); while (srdy !== 1'b1);
        @(posedge pclk);
        sv <= 1'b0;
    endtask
    task automatic idle();
        do @(negedge pclk); while (srdy !== 1'b1);
    endtask
    task automatic cfg(input logic en, input logic [5:0] f);
        @(posedge pclk);
        cc <= '{1'b1, en, fhf_chg_flags_t'(f)};
        @(posedge pclk);
        cc <= '{1'b0, 1'b0, fhf_chg_flags_t'(6'h00)};
    endtask
    function automatic fhf_sample_t mk(logic [2:0] en, logic [7:0] b);
        fhf_sample_t x;
        {x.aux_en, x.gyr_en, x.acc_en} = en;
        for (int i = 0; i < 8; i++) x.aux[8*i+:8] = b + 8'(i);
        for (int i = 0; i < 6; i++) x.gyr[8*i+:8] = b + 8'h10 + 8'(i);
        for (int i = 0; i < 6; i++) x.acc[8*i+:8] = b + 8'h20 + 8'(i);
        return x;
    endfunction
    function automatic fhf_bq_t frame(fhf_sample_t x, int al, logic [1:0] tg);
        fhf_bq_t q;
        q.push_back({`FHF_KIND_REG, 1'b0, x.aux_en, x.gyr_en, x.acc_en, tg});
        if (x.aux_en) for (int i = 0; i < al; i++) q.push_back(x.aux[8*i+:8]);
        if (x.gyr_en) for (int i = 0; i < 6; i++) q.push_back(x.gyr[8*i+:8]);
        if (x.acc_en) for (int i = 0; i < 6; i++) q.push_back(x.acc[8*i+:8]);
        return q;
    endfunction

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        fhf_bq_t q;
        pclk = 1'b0; presetn = 1'b0; sv = 1'b0; smp = '0; cc = '0;
        st = 24'hABCDEF; pin1 = 1'b0; pin2 = 1'b0; n_errors = 0; n_tests = 0; cyc = 0;
        rows = '{'{`FHF_OFF_CTRL, 32'h00000003, 1'b0}, '{`FHF_OFF_AUXLEN, 32'h00000008, 1'b0},
                 '{`FHF_OFF_LEN0, 32'h00000000, 1'b0}, '{`FHF_OFF_LEN1, 32'h00000000, 1'b0},
                 '{`FHF_OFF_SKIP, 32'h00000000, 1'b0}, '{8'h18, 32'h00000000, 1'b1},
                 '{`FHF_OFF_DATA, 32'h00000080, 1'b0}, '{`FHF_OFF_DATA, 32'h00000000, 1'b0}};
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rows[i]) begin
            rdreg(rows[i].a, rows[i].d);
            chk({31'h0, e}, {31'h0, rows[i].e});
        end
        s = mk(3'b111, 8'h40);
        push(s);
        idle();
        rdreg(`FHF_OFF_LEN0, 32'h00000015);
        rdq({frame(s, 8, 2'b00), 8'h44, 8'hEF, 8'hCD, 8'hAB, 8'h80, 8'h00});
        st <= 24'h123456;
        cfg(1'b0, 6'h2A);
        s = mk(3'b001, 8'h50);
        push(s);
        cfg(1'b1, 6'h15);
        idle();
        rdreg(`FHF_OFF_LEN0, 32'h00000011);
        rdq({8'h48, 8'h2A, 8'h56, 8'h34, 8'h12, frame(s, 8, 2'b00)});
        rdq({8'h48, 8'h00, 8'h56, 8'h34, 8'h12, 8'h44, 8'h56, 8'h34, 8'h12});
        wreg(`FHF_OFF_CTRL, 32'h0000000D);
        wreg(`FHF_OFF_AUXLEN, 32'h00000002);
        pin1 <= 1'b1;
        repeat (3) @(posedge pclk);
        s = mk(3'b100, 8'h60);
        push(s);
        push(mk(3'b000, 8'h00));
        idle();
        rdreg(`FHF_OFF_LEN0, 32'h00000003);
        rdq({frame(s, 2, 2'b01), 8'h80, 8'h00});
        pin2 <= 1'b1;
        repeat (3) @(posedge pclk);
        s = mk(3'b010, 8'h70);
        push(s);
        idle();
        q = frame(s, 2, 2'b11);
        rdq(q[0:2]);
        rdreg(`FHF_OFF_LEN0, 32'h00000007);
        rdq({q, 8'h80, 8'h00});
        wreg(`FHF_OFF_CTRL, 32'h00000000);
        cfg(1'b0, 6'h01);
        s = mk(3'b001, 8'h30);
        push(s);
        idle();
        rdreg(`FHF_OFF_LEN0, 32'h00000006);
        q = frame(s, 8, 2'b00);
        void'(q.pop_front());
        rdq(q);
        wreg(`FHF_OFF_CTRL, 32'h00000001);
        wreg(`FHF_OFF_AUXLEN, 32'h00000008);
        s = mk(3'b111, 8'h40);
        for (int i = 0; i < 100; i++) push(s);
        idle();
        rdreg(`FHF_OFF_LEN0, 32'h000000F5);
        rdreg(`FHF_OFF_LEN1, 32'h00000007);
        rdreg(`FHF_OFF_SKIP, 32'h00000003);
        for (int i = 0; i < 300; i++) push(s);
        idle();
        rdreg(`FHF_OFF_LEN0, 32'h000000F5);
        rdq({8'h40, 8'hFF, frame(s, 8, 2'b00)});
        rdreg(`FHF_OFF_SKIP, 32'h00000000);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rdreg(`FHF_OFF_LEN0, 32'h00000000);
        report_and_stop();
    end
endmodule // test_motion_fifo_header_framer
`default_nettype wire
